//--- core/vectored_interrupt_controller.v
// Notes on behaviour
// R01: Each maskable source picks one of four groups.
// R02: Higher group may interrupt a lower one in service.
// R03: Equal groups resolved by fixed default order.
// R04: Pending unmasked request releases stop and halt.
// R05: Thirteen external, twenty-five internal maskable sources.
// R06: Break instruction interrupts even with interrupts disabled.
// R07: Break interrupt skips group arbitration entirely.
// R08: Thirty-nine interrupt sources counting the break one.
// R09: Vectors are two bytes, below 64K.
// R10: Watchdog interval has top priority, vector 0004H.
// R11: Six pin edges, priorities two to seven.
// R12: Serial unit three: transmit, receive, error sources.
// R13: Each DMA channel end raises own request.
// R14: Serial zero modes share one transmit vector.
// R15: Serial one three modes share one transmit vector.
// R16: Two-wire bus controller end at priority nineteen.
// R17: Timers zero to three, priorities twenty onward.
// R18: Lower default number wins; zero is highest.
// R19: Break interrupt uses its own vector 007EH.
// R20: Acknowledge needs flag, unmasked, enable, outranking group.
// R21: Acknowledge clears flag and presents vector together.
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.vh"

module vectored_interrupt_controller (
  input wire clk,
  input wire rst,
  input wire watchdogIntervalIrq,
  input wire lowVoltageIrq,
  input wire [5:0] pinEdgeIrqLow,
  input wire serial3TxIrq,
  input wire serial3RxIrq,
  input wire serial3RxErrIrq,
  input wire dmaCh0DoneIrq,
  input wire dmaCh1DoneIrq,
  input wire serial0TxIrq,
  input wire clockedSerial0Irq,
  input wire serial0RxIrq,
  input wire serial0RxErrIrq,
  input wire serial1TxIrq,
  input wire clockedSerial1Irq,
  input wire twoWireSerial1Irq,
  input wire serial1RxIrq,
  input wire serial1RxErrIrq,
  input wire twoWireBusDoneIrq,
  input wire [3:0] timerChIrqLow,
  input wire [13:0] laterIrq,
  input wire [`VIC_NUM_SRC-1:0] flagSet,
  input wire [`VIC_NUM_SRC-1:0] flagClear,
  input wire [`VIC_NUM_SRC-1:0] maskFlag,
  input wire [`VIC_NUM_SRC-1:0] priorityGroupBits0,
  input wire [`VIC_NUM_SRC-1:0] priorityGroupBits1,
  input wire globalIrqEnable,
  input wire breakInstruction,
  input wire irqAck,
  input wire irqReturn,
  output wire [`VIC_NUM_SRC-1:0] requestFlags,
  output wire irqRequest,
  output wire [`VIC_VEC_W-1:0] vectorAddr,
  output wire softwareIrq,
  output wire [`VIC_IDX_W-1:0] ackSource,
  output wire [`VIC_LEVEL_W-1:0] inServiceLevel,
  output wire [`VIC_NUM_GROUPS-1:0] inServiceGroups,
  output wire standbyRelease
);

  // Event lines in default-priority order. Shared transmit vectors simply
  // merge the mode-specific events, since only one mode runs at a time.
  // The bit order is the default priority order: bit 0 wins all ties.
  wire [`VIC_NUM_SRC-1:0] rawEvent;
  assign rawEvent[0] = watchdogIntervalIrq; // R10
  assign rawEvent[1] = lowVoltageIrq;
  assign rawEvent[7:2] = pinEdgeIrqLow; // R11
  assign rawEvent[8] = serial3TxIrq; // R12
  assign rawEvent[9] = serial3RxIrq;
  assign rawEvent[10] = serial3RxErrIrq;
  assign rawEvent[11] = dmaCh0DoneIrq; // R13
  assign rawEvent[12] = dmaCh1DoneIrq;
  assign rawEvent[13] = serial0TxIrq | clockedSerial0Irq; // R14
  assign rawEvent[14] = serial0RxIrq;
  assign rawEvent[15] = serial0RxErrIrq;
  assign rawEvent[16] = serial1TxIrq | clockedSerial1Irq |
    twoWireSerial1Irq; // R15
  assign rawEvent[17] = serial1RxIrq;
  assign rawEvent[18] = serial1RxErrIrq;
  assign rawEvent[19] = twoWireBusDoneIrq; // R16
  assign rawEvent[23:20] = timerChIrqLow; // R17
  assign rawEvent[37:24] = laterIrq; // R05 R08

  // Registered request toward the core and its bookkeeping.
  // The offer is rebuilt every cycle, so a higher winner may replace a
  // lower one until the core acknowledges it.
  reg reqValid_q;
  reg reqValid_d;
  reg reqSoftware_q;
  reg reqSoftware_d;
  reg [`VIC_IDX_W-1:0] reqIdx_q;
  reg [`VIC_IDX_W-1:0] reqIdx_d;
  reg [`VIC_GROUP_W-1:0] reqGroup_q;
  reg [`VIC_GROUP_W-1:0] reqGroup_d;
  reg [`VIC_VEC_W-1:0] vector_q;
  reg [`VIC_VEC_W-1:0] vector_d;
  reg breakPend_q;
  reg breakPend_d;
  reg [`VIC_NUM_GROUPS-1:0] inService_q;
  reg [`VIC_NUM_GROUPS-1:0] inService_d;
  wire [`VIC_NUM_SRC-1:0] flag_q;

  // The acknowledge only counts while a request is actually offered.
  // An acknowledge with no offer standing is ignored, not remembered.
  wire ackTaken;
  wire ackMaskable;
  wire ackBreak;
  assign ackTaken = irqAck & reqValid_q;
  assign ackMaskable = ackTaken & ~reqSoftware_q;
  assign ackBreak = ackTaken & reqSoftware_q;

  // Per-source request flags. A new event beats any clear in the same
  // cycle, so a request arriving during its own acknowledge is kept.
  // Each flag bit is its own flip-flop inside the loop and reaches the
  // shared vector through one continuous assignment, so no bit of the
  // vector has more than one driver.
  genvar g;
  generate
    for (g = 0; g < `VIC_NUM_SRC; g = g + 1) begin : srcFlag
      localparam [`VIC_IDX_W-1:0] SRC_IDX = g;
      wire ackHere;
      reg flagBit_q;
      assign ackHere = ackMaskable && (reqIdx_q == SRC_IDX);
      always @(posedge clk) begin
        if (rst) begin
          flagBit_q <= 1'b0;
        end else if (rawEvent[g] | flagSet[g]) begin
          flagBit_q <= 1'b1;
        end else if (flagClear[g] | ackHere) begin
          flagBit_q <= 1'b0; // R21
        end
      end
      assign flag_q[g] = flagBit_q;
    end
  endgenerate

  // Only flags whose mask is clear take part in arbitration.
  // The mask is sampled every cycle, so masking withdraws a standing offer.
  wire [`VIC_NUM_SRC-1:0] pending;
  assign pending = flag_q & ~maskFlag; // R20

  wire anyPending;
  wire [`VIC_IDX_W-1:0] winIdx;
  wire [`VIC_GROUP_W-1:0] winGroup;

  // Arbitration is purely combinational; its result is registered in the
  // offer logic below, which keeps the path to the core short.
  vic_priority_arbiter arbiter (
    .pending(pending),
    .groupBit0(priorityGroupBits0),
    .groupBit1(priorityGroupBits1),
    .anyPending(anyPending),
    .winIdx(winIdx),
    .winGroup(winGroup)
  );

  wire [`VIC_VEC_W-1:0] winVector;

  // The vector of the current winner is looked up in parallel, so the
  // offer and its vector always come from the same cycle.
  vic_vector_table vectorTable (
    .srcIdx(winIdx),
    .vectorAddr(winVector)
  );

  // Current in-service level is the highest group still being served;
  // idle means no maskable handler is active and any group may enter.
  // Level 4 is one step below group 3, so every group outranks idle.
  reg [`VIC_LEVEL_W-1:0] curLevel;
  always @* begin
    if (inService_q[0]) begin
      curLevel = 3'h0;
    end else if (inService_q[1]) begin
      curLevel = 3'h1;
    end else if (inService_q[2]) begin
      curLevel = 3'h2;
    end else if (inService_q[3]) begin
      curLevel = 3'h3;
    end else begin
      curLevel = `VIC_LEVEL_IDLE;
    end
  end

  // A maskable winner is offered only when enabled and strictly above the
  // level in service; equal groups wait for the running handler to end.
  // This is what lets a group 1 request nest over a group 2 handler.
  wire maskableEligible;
  assign maskableEligible = anyPending & globalIrqEnable &
    ({1'b0, winGroup} < curLevel); // R02 R20

  // Break request latch. It sets on the instruction and clears on its
  // acknowledge; a new instruction in the same cycle keeps it set.
  // The break interrupt has no flag or mask of its own, only this latch.
  always @* begin
    breakPend_d = breakPend_q;
    if (ackBreak) begin
      breakPend_d = 1'b0;
    end
    if (breakInstruction) begin
      breakPend_d = 1'b1; // R06
    end
  end

  // Offer selection. The break interrupt is ranked ahead of everything and
  // ignores the enable and the group levels. After any acknowledge the
  // offer drops for one cycle so a stale winner is never offered twice.
  always @* begin
    reqValid_d = 1'b0;
    reqSoftware_d = 1'b0;
    reqIdx_d = reqIdx_q;
    reqGroup_d = reqGroup_q;
    vector_d = vector_q;
    if (ackTaken) begin
      reqValid_d = 1'b0;
    end else if (breakPend_q) begin
      reqValid_d = 1'b1;
      reqSoftware_d = 1'b1; // R07
      vector_d = `VIC_VEC_BREAK; // R19
    end else if (maskableEligible) begin
      reqValid_d = 1'b1;
      reqIdx_d = winIdx;
      reqGroup_d = winGroup;
      vector_d = winVector; // R09
    end
  end

  // In-service tracking. Entry marks the accepted group; a return from a
  // maskable handler retires the highest group in service, which is the
  // innermost nested one. Break entry marks no group, but a return after a break handler retires one too.
  // A return with no group in service changes nothing.
  always @* begin
    inService_d = inService_q;
    if (irqReturn) begin
      if (inService_q[0]) begin
        inService_d[0] = 1'b0;
      end else if (inService_q[1]) begin
        inService_d[1] = 1'b0;
      end else if (inService_q[2]) begin
        inService_d[2] = 1'b0;
      end else begin
        inService_d[3] = 1'b0;
      end
    end
    if (ackMaskable) begin
      inService_d[reqGroup_q] = 1'b1; // R02
    end
  end

  // State registers.
  // The in-service groups clear only on a return or reset and the break latch on its
  // acknowledge or reset; a handler that never returns keeps its group blocked until then.
  always @(posedge clk) begin
    if (rst) begin
      reqValid_q <= 1'b0;
      reqSoftware_q <= 1'b0;
      reqIdx_q <= {`VIC_IDX_W{1'b0}};
      reqGroup_q <= 2'h0;
      vector_q <= {`VIC_VEC_W{1'b0}};
      breakPend_q <= 1'b0;
      inService_q <= {`VIC_NUM_GROUPS{1'b0}};
    end else begin
      reqValid_q <= reqValid_d;
      reqSoftware_q <= reqSoftware_d;
      reqIdx_q <= reqIdx_d;
      reqGroup_q <= reqGroup_d;
      vector_q <= vector_d;
      breakPend_q <= breakPend_d;
      inService_q <= inService_d;
    end
  end

  // Standby release follows any unmasked pending flag and ignores the
  // global enable, so a sleeping core wakes even with interrupts off.
  // The one-cycle register delay is harmless: waking is not time critical.
  reg standby_q;
  always @(posedge clk) begin
    if (rst) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= |pending; // R04
    end
  end

  // Outputs.
  // Level and groups are views of one register, so they never disagree.
  assign requestFlags = flag_q;
  assign irqRequest = reqValid_q;
  assign vectorAddr = vector_q; // R21
  assign softwareIrq = reqSoftware_q;
  assign ackSource = reqIdx_q;
  assign inServiceLevel = curLevel;
  assign inServiceGroups = inService_q;
  assign standbyRelease = standby_q;

endmodule

`default_nettype wire

//--- core/vic_defs.vh
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH

// Source counts: thirteen external and twenty-five internal maskable sources.
`define VIC_NUM_EXT 13
`define VIC_NUM_INT 25
`define VIC_NUM_SRC 38
`define VIC_IDX_W 6
`define VIC_LAST_IDX 6'h25

// Priority groups: two specification bits per source, group 0 is highest.
`define VIC_GROUP_W 2
`define VIC_NUM_GROUPS 4
`define VIC_LEVEL_W 3
`define VIC_LEVEL_IDLE 3'h4

// Default-priority indexes of fixed sources.
`define VIC_IDX_WDT 6'h00
`define VIC_IDX_LVI 6'h01
`define VIC_IDX_PIN0 6'h02
`define VIC_IDX_SER3_TX 6'h08
`define VIC_IDX_DMA0 6'h0B
`define VIC_IDX_SER0_TX 6'h0D
`define VIC_IDX_SER1_TX 6'h10
`define VIC_IDX_TWI_DONE 6'h13
`define VIC_IDX_TIMER0 6'h14
`define VIC_IDX_SEG_B 6'h18
`define VIC_IDX_SEG_C 6'h1C

// Vector table: two-byte entries inside the first 64K of program space.
`define VIC_VEC_W 16
`define VIC_VEC_BASE_A 16'h0004
`define VIC_VEC_BASE_B 16'h0034
`define VIC_VEC_BASE_C 16'h0042
`define VIC_VEC_BREAK 16'h007E
`define VIC_VEC_STEP 16'h0002

`endif

//--- core/vic_priority_arbiter.v
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.vh"

module vic_priority_arbiter (
  input wire [`VIC_NUM_SRC-1:0] pending,
  input wire [`VIC_NUM_SRC-1:0] groupBit0,
  input wire [`VIC_NUM_SRC-1:0] groupBit1,
  output reg anyPending,
  output reg [`VIC_IDX_W-1:0] winIdx,
  output reg [`VIC_GROUP_W-1:0] winGroup
);

  integer i;
  reg [`VIC_GROUP_W-1:0] grp;

  // Scan from the lowest default priority upward; a source replaces the
  // current pick when its group is at least as high, so the lower index
  // wins among equals.
  always @* begin
    grp = 2'h0;
    anyPending = 1'b0;
    winIdx = {`VIC_IDX_W{1'b0}};
    winGroup = 2'h3;
    for (i = `VIC_NUM_SRC - 1; i >= 0; i = i - 1) begin
      grp = {groupBit1[i], groupBit0[i]};
      if (pending[i] && (!anyPending || grp <= winGroup)) begin // R03 R18
        anyPending = 1'b1;
        winIdx = i[`VIC_IDX_W-1:0];
        winGroup = grp; // R01
      end
    end
  end

endmodule

`default_nettype wire

//--- core/vic_vector_table.v
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.vh"

module vic_vector_table (
  input wire [`VIC_IDX_W-1:0] srcIdx,
  output reg [`VIC_VEC_W-1:0] vectorAddr
);

  reg [`VIC_VEC_W-1:0] offs;

  // Three runs of two-byte entries; the first two adjoin, and the gap between the
  // second and third holds vectors of other functions and is never produced here.
  always @* begin
    offs = {{(`VIC_VEC_W-`VIC_IDX_W){1'b0}}, srcIdx};
    if (srcIdx >= `VIC_IDX_SEG_C) begin
      vectorAddr = `VIC_VEC_BASE_C + `VIC_VEC_STEP *
        (offs - {10'h000, `VIC_IDX_SEG_C});
    end else if (srcIdx >= `VIC_IDX_SEG_B) begin
      vectorAddr = `VIC_VEC_BASE_B + `VIC_VEC_STEP *
        (offs - {10'h000, `VIC_IDX_SEG_B});
    end else begin
      vectorAddr = `VIC_VEC_BASE_A + `VIC_VEC_STEP * offs; // R09 R10 R11
    end
  end

endmodule

`default_nettype wire

//--- tb/vic_chk.sv
`timescale 1ns/1ps
`default_nettype none
module vic_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic irqRequest,
  input wire logic irqAck,
  input wire logic softwareIrq,
  input wire logic breakInstruction,
  input wire logic globalIrqEnable,
  input wire logic standbyRelease,
  input wire logic [15:0] vectorAddr,
  input wire logic [5:0] ackSource,
  input wire logic [2:0] inServiceLevel,
  input wire logic [37:0] requestFlags,
  input wire logic [37:0] maskFlag,
  input wire logic [37:0] priorityGroupBits0,
  input wire logic [37:0] priorityGroupBits1
);
  logic [37:0] fQ, mQ, g0Q, g1Q;
  logic [2:0] lQ;
  logic eQ;
  // Offers are registered, so they are judged against last cycle's state.
  always_ff @(posedge clk) begin
    fQ <= requestFlags;
    mQ <= maskFlag;
    g0Q <= priorityGroupBits0;
    g1Q <= priorityGroupBits1;
    lQ <= inServiceLevel;
    eQ <= globalIrqEnable;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_break_vector:
    assert property (softwareIrq |-> irqRequest && vectorAddr == 16'h007E)
    else $error("break offer has a wrong vector");
  a_break_taken:
    assert property (breakInstruction && !irqAck |-> ##[1:3] softwareIrq)
    else $error("break not offered");
  a_standby_tracks:
    assert property (standbyRelease == |(fQ & ~mQ))
    else $error("standby release wrong");
  a_vector_step:
    assert property (irqRequest && !softwareIrq && ackSource < 6'h18
      |-> vectorAddr == 16'h0004 + {9'h000, ackSource, 1'b0})
    else $error("vector not tied to source");
  a_ack_gap:
    assert property (irqRequest && irqAck |=> !irqRequest)
    else $error("offer kept after acknowledge");
  a_ack_level:
    assert property (irqRequest && irqAck && !softwareIrq |=> inServiceLevel
      == {1'b0, g1Q[$past(ackSource)], g0Q[$past(ackSource)]})
    else $error("service level not the taken group");
  a_offer_eligible:
    assert property (irqRequest && !softwareIrq
      |-> fQ[ackSource] && !mQ[ackSource] && eQ)
    else $error("offer of an ineligible source");
  a_group_outranks:
    assert property (irqRequest && !softwareIrq
      |-> {g1Q[ackSource], g0Q[ackSource]} < lQ)
    else $error("offer does not outrank service level");
endmodule
bind vectored_interrupt_controller vic_chk chk (.clk(clk), .rst(rst),
  .irqRequest(irqRequest), .irqAck(irqAck), .softwareIrq(softwareIrq),
  .breakInstruction(breakInstruction), .globalIrqEnable(globalIrqEnable),
  .standbyRelease(standbyRelease), .vectorAddr(vectorAddr),
  .ackSource(ackSource), .inServiceLevel(inServiceLevel),
  .requestFlags(requestFlags), .maskFlag(maskFlag),
  .priorityGroupBits0(priorityGroupBits0),
  .priorityGroupBits1(priorityGroupBits1));
`default_nettype wire

//--- tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irqRequest,
  input wire logic [15:0] vectorAddr,
  input wire logic ackOn,
  input wire logic slow,
  output logic irqAck,
  output logic [15:0] takenVec
);
  logic waitQ;
  // A slow core idles one cycle before taking an offer; it holds its
  // acknowledge until the edge that samples it, then takes the vector.
  always_ff @(posedge clk) begin
    irqAck <= 1'b0;
    waitQ <= 1'b0;
    if (irqRequest && irqAck)
      takenVec <= vectorAddr;
    if (rst)
      takenVec <= 16'h0000;
    else if (irqRequest && !irqAck && ackOn) begin
      waitQ <= !waitQ;
      irqAck <= waitQ | !slow;
    end
  end
endmodule
`default_nettype wire

//--- tb/vectored_interrupt_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [40:0] ev = '0;
  logic [37:0] fSet = '0;
  logic [37:0] fClr = '0;
  logic [37:0] mask = '0;
  logic [37:0] pg0 = '1;
  logic [37:0] pg1 = '1;
  logic en = 1'b1;
  logic break_instruction = 1'b0;
  logic ret = 1'b0;
  logic ackOn = 1'b1;
  logic slow = 1'b1;
  wire [37:0] flags;
  wire [15:0] vec, tVec;
  wire [5:0] src;
  wire [2:0] lvl;
  wire [3:0] isg;
  wire req, ack, sw, stby;
  int n_fail = 0;
  int compares = 0;
  // Rows: port bit, expected source index, expected vector.
  logic [31:0] rows [20] = '{32'h00000004, 32'h01010006, 32'h02020008,
    32'h07070012, 32'h08080014, 32'h0A0A0018, 32'h0B0B001A, 32'h0C0C001C,
    32'h260D001E, 32'h0F0F0022, 32'h10100024, 32'h27100024, 32'h28100024,
    32'h12120028, 32'h1313002A, 32'h1414002C, 32'h17170032, 32'h18180034,
    32'h1C1C0042, 32'h25250054};
  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;
  vectored_interrupt_controller uut (.clk(clk), .rst(rst),
    .watchdogIntervalIrq(ev[0]), .lowVoltageIrq(ev[1]),
    .pinEdgeIrqLow(ev[7:2]), .serial3TxIrq(ev[8]), .serial3RxIrq(ev[9]),
    .serial3RxErrIrq(ev[10]), .dmaCh0DoneIrq(ev[11]),
    .dmaCh1DoneIrq(ev[12]), .serial0TxIrq(ev[13]),
    .clockedSerial0Irq(ev[38]), .serial0RxIrq(ev[14]),
    .serial0RxErrIrq(ev[15]), .serial1TxIrq(ev[16]),
    .clockedSerial1Irq(ev[39]), .twoWireSerial1Irq(ev[40]),
    .serial1RxIrq(ev[17]), .serial1RxErrIrq(ev[18]),
    .twoWireBusDoneIrq(ev[19]), .timerChIrqLow(ev[23:20]),
    .laterIrq(ev[37:24]), .flagSet(fSet), .flagClear(fClr),
    .maskFlag(mask), .priorityGroupBits0(pg0), .priorityGroupBits1(pg1),
    .globalIrqEnable(en), .breakInstruction(break_instruction), .irqAck(ack),
    .irqReturn(ret), .requestFlags(flags), .irqRequest(req),
    .vectorAddr(vec), .softwareIrq(sw), .ackSource(src),
    .inServiceLevel(lvl), .inServiceGroups(isg), .standbyRelease(stby));
  core_model core (.clk(clk), .rst(rst), .irqRequest(req),
    .vectorAddr(vec), .ackOn(ackOn), .slow(slow), .irqAck(ack),
    .takenVec(tVec));
  task automatic chk(input string nm, input logic [37:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for the offer line; running out ends the run.
  task automatic waitReq(input logic want);
    int i;
    for (i = 0; i < 20 && req !== want; i++) begin
      @(posedge clk);
      #1;
    end
    if (req !== want) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic fire(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask
  task automatic retire;
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    #1;
  endtask
  initial begin
    int i;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // For each of the twenty table rows, its source alone is offered, taken by the core and retired.
    for (i = 0; i < 20; i++) begin
      fire(rows[i][31:24]);
      waitReq(1'b1);
      chk("vector", rows[i][15:0], vec);
      chk("source", rows[i][21:16], src);
      waitReq(1'b0);
      chk("level", 3'h3, lvl);
      chk("flags", '0, flags);
      chk("taken", rows[i][15:0], tVec);
      retire();
      $display("row %0d done", i);
    end
    // Equal groups arriving together: the lower default number wins.
    ackOn <= 1'b0;
    slow <= 1'b0;
    @(posedge clk);
    ev <= 41'h28;
    @(posedge clk);
    ev <= '0;
    waitReq(1'b1);
    chk("tie", 6'h03, src);
    @(posedge clk);
    fClr <= 38'h28;
    @(posedge clk);
    fClr <= '0;
    waitReq(1'b0);
    $display("tie done");
    // Higher group nests over group 2; group 3 must wait.
    @(posedge clk);
    pg0[20] <= 1'b0;
    pg1[9] <= 1'b0;
    ackOn <= 1'b1;
    fire(20);
    waitReq(1'b1);
    waitReq(1'b0);
    chk("level g2", 3'h2, lvl);
    ackOn <= 1'b0;
    fire(30);
    repeat (3) @(posedge clk);
    #1;
    chk("held", 1'b0, req);
    fire(9);
    waitReq(1'b1);
    chk("nested", 6'h09, src);
    ackOn <= 1'b1;
    waitReq(1'b0);
    ackOn <= 1'b0;
    chk("groups", 4'h6, isg);
    retire();
    chk("level back", 3'h2, lvl);
    $display("nesting done");
    // Break is taken with interrupts off and leaves service alone.
    @(posedge clk);
    en <= 1'b0;
    break_instruction <= 1'b1;
    @(posedge clk);
    break_instruction <= 1'b0;
    waitReq(1'b1);
    chk("soft", 1'b1, sw);
    chk("soft vector", 16'h007E, vec);
    ackOn <= 1'b1;
    waitReq(1'b0);
    ackOn <= 1'b0;
    chk("soft level", 3'h2, lvl);
    @(posedge clk);
    en <= 1'b1;
    retire();
    waitReq(1'b1);
    chk("late vector", 16'h0046, vec);
    $display("break done");
    // Masking silences offer and release; the enable gates the offer only.
    @(posedge clk);
    mask[30] <= 1'b1;
    waitReq(1'b0);
    chk("masked", 1'b0, stby);
    @(posedge clk);
    mask[30] <= 1'b0;
    en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("release", 1'b1, stby);
    chk("disabled", 1'b0, req);
    // A second reset wipes flags and service state.
    @(posedge clk);
    fSet[6] <= 1'b1;
    @(posedge clk);
    fSet[6] <= 1'b0;
    #1;
    chk("flag set", 1'b1, flags[6]);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("rst flags", '0, flags);
    chk("rst level", 3'h4, lvl);
    chk("rst out", 2'h0, {req, stby});
    $display("reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
